// File: src/ppi_consts.vh
// Register offsets, field positions and reset values of the port interrupt block
`ifndef PPI_CONSTS_VH
`define PPI_CONSTS_VH

// Printed register indices (not all multiples of four)
`define PPI_IDX_P0_FLAGS    8'h89
`define PPI_IDX_P1_FLAGS    8'h8a
`define PPI_IDX_P2_FLAGS    8'h8b
`define PPI_IDX_CONTROL     8'h8c
`define PPI_IDX_P1_MASK     8'h8d
// Own registers for the interrupt status and mask
`define PPI_IDX_IRQ_STATUS  8'h90
`define PPI_IDX_IRQ_MASK    8'h91

// Address decode: index is byte address bits 9:2
`define PPI_ADDR_W          10
`define PPI_IDX_HI          9
`define PPI_IDX_LO          2

// Control register field positions
`define PPI_CTL_PAD_DRIVE   6
`define PPI_CTL_P2_EN       5
`define PPI_CTL_P0_HI_EN    4
`define PPI_CTL_P0_LO_EN    3
`define PPI_CTL_P2_EDGE     2
`define PPI_CTL_P1_EDGE     1
`define PPI_CTL_P0_EDGE     0
`define PPI_CTL_USED        8'h7f

// Port widths and reset values
`define PPI_P2_W            5
`define PPI_RST8            8'h00
`define PPI_RST5            5'h00
`define PPI_RST3            3'h0
`define PPI_RST7            7'h00
`define PPI_CTL_W           7

// Interrupt status layout: one bit per port
`define PPI_IRQ_W           3

// AXI responses
`define PPI_RESP_OKAY       2'b00
`define PPI_RESP_SLVERR     2'b10

`endif

// File: src/ppi_port_irq.v
// Edge-triggered interrupt logic for three general-purpose input ports
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ppi_consts.vh"

module ppi_port_irq (
  input  wire        ref_clk,
  input  wire        reset_n,
  // Port pins
  input  wire [7:0]  port0_in,
  input  wire [7:0]  port1_in,
  input  wire [4:0]  port2_in,
  output reg         pad_drive_select,
  output reg         port0_irq,
  output reg         port1_irq,
  output reg         port2_irq,
  output reg         irq,
  // AXI4-Lite slave
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // Register index from a byte address
  // Byte lanes within a word are not decoded; the low address
  // bits are dropped, so any byte address in a word hits it
  function [7:0] reg_index;
    input [9:0] addr;
    begin
      reg_index = addr[`PPI_IDX_HI:`PPI_IDX_LO];
    end
  endfunction

  // Selected edge: rising when edge bit is zero, falling when one
  function [7:0] edge_hits;
    input [7:0] cur;
    input [7:0] prev;
    input       falling;
    begin
      if (falling) begin
        // High before, low now
        edge_hits = prev & ~cur;
      end else begin
        // Low before, high now
        edge_hits = cur & ~prev;
      end
    end
  endfunction

  // Flag update: hardware set wins over a software zero write
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] set;
    input       wr;
    input [7:0] wval;
    begin
      if (wr) begin
        // A zero clears, a one keeps; new edges still land
        flag_next = (cur & wval) | set;
      end else begin
        // No write: flags only collect new edges
        flag_next = cur | set;
      end
    end
  endfunction

  // Two-stage synchronisers and edge history
  // Old sample keeps the last settled level for the edge compare
  reg  [7:0] p0_s1_q, p0_s2_q, p0_old_q;
  reg  [7:0] p1_s1_q, p1_s2_q, p1_old_q;
  reg  [4:0] p2_s1_q, p2_s2_q, p2_old_q;

  // Software-visible state
  reg  [7:0] p0_flags_q;               // Port 0 pending flags
  reg  [7:0] p1_flags_q;               // Port 1 pending flags
  reg  [4:0] p2_flags_q;               // Port 2 pending flags
  reg  [6:0] ctl_q;                    // Control, bit 7 absent
  reg  [7:0] p1_mask_q;                // Port 1 per-pin enable
  reg  [2:0] irq_stat_q;               // Sticky per-port events
  reg  [2:0] irq_mask_q;               // Mask for the irq output

  // Write channel holding registers
  reg        aw_have_q;
  reg  [9:0] aw_addr_q;
  reg        w_have_q;
  reg [31:0] w_data_q;
  reg  [3:0] w_strb_q;

  // Edge detection on synchronised pins
  // The select acts on the history compare, not on the pin, so
  // flipping it creates no edge by itself
  wire [7:0] p0_hit;
  wire [7:0] p1_hit;
  wire [7:0] p2_hit8;
  wire [4:0] p2_hit;
  assign p0_hit = edge_hits(p0_s2_q, p0_old_q,
                            ctl_q[`PPI_CTL_P0_EDGE]);
  assign p1_hit = edge_hits(p1_s2_q, p1_old_q,
                            ctl_q[`PPI_CTL_P1_EDGE]);
  assign p2_hit8 = edge_hits({`PPI_RST3, p2_s2_q},
                             {`PPI_RST3, p2_old_q},
                             ctl_q[`PPI_CTL_P2_EDGE]);
  assign p2_hit = p2_hit8[`PPI_P2_W-1:0];

  // Write commit happens once both halves are held and no reply waits
  // Holding the reply blocks a second commit, so a new write waits
  wire       wr_go;
  wire [7:0] wr_idx;
  wire       wr_lane0;
  wire [7:0] wr_byte;
  assign wr_go    = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_idx   = reg_index(aw_addr_q);
  assign wr_lane0 = wr_go & w_strb_q[0];
  assign wr_byte  = w_data_q[7:0];

  wire wr_p0   = wr_lane0 & (wr_idx == `PPI_IDX_P0_FLAGS);
  wire wr_p1   = wr_lane0 & (wr_idx == `PPI_IDX_P1_FLAGS);
  wire wr_p2   = wr_lane0 & (wr_idx == `PPI_IDX_P2_FLAGS);
  wire wr_ctl  = wr_lane0 & (wr_idx == `PPI_IDX_CONTROL);
  wire wr_p1m  = wr_lane0 & (wr_idx == `PPI_IDX_P1_MASK);
  wire wr_ist  = wr_lane0 & (wr_idx == `PPI_IDX_IRQ_STATUS);
  wire wr_imk  = wr_lane0 & (wr_idx == `PPI_IDX_IRQ_MASK);
  // Decode hit for the response code only
  wire wr_hit  = (wr_idx == `PPI_IDX_P0_FLAGS) |
                 (wr_idx == `PPI_IDX_P1_FLAGS) |
                 (wr_idx == `PPI_IDX_P2_FLAGS) |
                 (wr_idx == `PPI_IDX_CONTROL)  |
                 (wr_idx == `PPI_IDX_P1_MASK)  |
                 (wr_idx == `PPI_IDX_IRQ_STATUS) |
                 (wr_idx == `PPI_IDX_IRQ_MASK);

  // Next pending flags
  // Port 2 is worked at byte width; its top bits stay zero
  wire [7:0] p0_flags_d = flag_next(p0_flags_q, p0_hit,
                                    wr_p0, wr_byte);
  wire [7:0] p1_flags_d = flag_next(p1_flags_q, p1_hit,
                                    wr_p1, wr_byte);
  wire [7:0] p2_flags_w = flag_next({`PPI_RST3, p2_flags_q},
                                    {`PPI_RST3, p2_hit},
                                    wr_p2, wr_byte);
  wire [4:0] p2_flags_d = p2_flags_w[`PPI_P2_W-1:0];

  // Per-port requests from enabled flags
  // Port 1 uses its per-pin mask, ports 0 and 2 group enables
  wire p0_req_d = |(p0_flags_d[7:4] & {4{ctl_q[`PPI_CTL_P0_HI_EN]}})
                | |(p0_flags_d[3:0] & {4{ctl_q[`PPI_CTL_P0_LO_EN]}});
  wire p1_req_d = |(p1_flags_d & p1_mask_q);
  wire p2_req_d = |(p2_flags_d & {5{ctl_q[`PPI_CTL_P2_EN]}});

  // Sticky status: rising request sets, write one clears, set wins
  wire [2:0] irq_evt = {p2_req_d & ~port2_irq,
                        p1_req_d & ~port1_irq,
                        p0_req_d & ~port0_irq};
  wire [2:0] irq_clr = wr_ist ? wr_byte[`PPI_IRQ_W-1:0] : `PPI_RST3;
  wire [2:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
  wire [2:0] irq_mask_d = wr_imk ? wr_byte[`PPI_IRQ_W-1:0] : irq_mask_q;

  // Pin synchronisers; first stage feeds only the second
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Pins count as low until sampled
      p0_s1_q  <= `PPI_RST8;
      p0_s2_q  <= `PPI_RST8;
      p0_old_q <= `PPI_RST8;
      p1_s1_q  <= `PPI_RST8;
      p1_s2_q  <= `PPI_RST8;
      p1_old_q <= `PPI_RST8;
      p2_s1_q  <= `PPI_RST5;
      p2_s2_q  <= `PPI_RST5;
      p2_old_q <= `PPI_RST5;
    end else begin
      // Shift pins through two stages, then keep history
      p0_s1_q  <= port0_in;
      p0_s2_q  <= p0_s1_q;
      p0_old_q <= p0_s2_q;
      p1_s1_q  <= port1_in;
      p1_s2_q  <= p1_s1_q;
      p1_old_q <= p1_s2_q;
      p2_s1_q  <= port2_in;
      p2_s2_q  <= p2_s1_q;
      p2_old_q <= p2_s2_q;
    end
  end
  // Note: a pin high at reset release reads as a rising edge once,
  // because the history starts at zero; software clears it after init.

  // Flags, control, masks and interrupt outputs
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // All software state starts cleared
      p0_flags_q       <= `PPI_RST8;
      p1_flags_q       <= `PPI_RST8;
      p2_flags_q       <= `PPI_RST5;
      ctl_q            <= `PPI_RST7;
      p1_mask_q        <= `PPI_RST8;
      irq_stat_q       <= `PPI_RST3;
      irq_mask_q       <= `PPI_RST3;
      pad_drive_select <= 1'b0;
      port0_irq        <= 1'b0;
      port1_irq        <= 1'b0;
      port2_irq        <= 1'b0;
      irq              <= 1'b0;
    end else begin
      // Flags always follow the merged set and clear result
      p0_flags_q <= p0_flags_d;
      p1_flags_q <= p1_flags_d;
      p2_flags_q <= p2_flags_d;
      // Bit 7 is never stored
      if (wr_ctl) begin
        ctl_q <= wr_byte[`PPI_CTL_W-1:0];
      end
      if (wr_p1m) begin
        p1_mask_q <= wr_byte;
      end
      // Status and mask of the own interrupt registers
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      // Drive select takes written control bit 6 on the same edge as ctl_q
      if (wr_ctl) begin
        pad_drive_select <= wr_byte[`PPI_CTL_PAD_DRIVE];
      end
      // Requests follow the next flag state, no extra lag
      port0_irq <= p0_req_d;
      port1_irq <= p1_req_d;
      port2_irq <= p2_req_d;
      irq       <= |(irq_stat_d & irq_mask_d);
    end
  end

  // AXI write: address and data taken in either order, one at a time
  // Only byte lane 0 carries register bits; other lanes are ignored
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // No transfer in flight after reset
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PPI_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 10'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else begin
      // Ready is a one-cycle pulse offered while the slot is empty
      s_axi_awready <= ~aw_have_q & s_axi_awvalid & ~s_axi_awready;
      s_axi_wready  <= ~w_have_q & s_axi_wvalid & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready) begin
        // Address held until the data is also in
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        // Data held until the address is also in
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      // Commit and answer; unmapped address gets SLVERR
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PPI_RESP_OKAY : `PPI_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        // Master took the response
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux; reserved bits read zero
  // Address is decoded live and never stored; only the mux result is captured, at the handshake
  reg [31:0] rd_word;
  reg        rd_hit;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (reg_index(s_axi_araddr))
      `PPI_IDX_P0_FLAGS:   rd_word[7:0] = p0_flags_q;
      `PPI_IDX_P1_FLAGS:   rd_word[7:0] = p1_flags_q;
      `PPI_IDX_P2_FLAGS:   rd_word[4:0] = p2_flags_q;
      `PPI_IDX_CONTROL:    rd_word[`PPI_CTL_W-1:0] = ctl_q;
      `PPI_IDX_P1_MASK:    rd_word[7:0] = p1_mask_q;
      `PPI_IDX_IRQ_STATUS: rd_word[2:0] = irq_stat_q;
      `PPI_IDX_IRQ_MASK:   rd_word[2:0] = irq_mask_q;
      default:             rd_hit = 1'b0;
    endcase
  end

  // AXI read: arready pulse, data one cycle after, held until taken
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Read side idle
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PPI_RESP_OKAY;
    end else begin
      // No new address while data still waits
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        // Capture data and response together
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `PPI_RESP_OKAY : `PPI_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        // Master took the data
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// File: verif/ppi_props.sv
// Checker of port-level timing for the port interrupt block
`timescale 1ns/10ps
module ppi_props (
  input wire        ref_clk,
  input wire        reset_n,
  input wire [7:0]  port0_in,
  input wire [7:0]  port1_in,
  input wire [4:0]  port2_in,
  input wire        pad_drive_select,
  input wire        port0_irq,
  input wire        port1_irq,
  input wire        port2_irq,
  input wire        irq,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata
);
  // Recent pin activity; sync plus detect lags a few edges
  reg [20:0] pins_q;                   // Pin levels one edge ago
  reg [5:0]  hist_q;                   // One bit per edge, newest low
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_q <= 21'h00_0000;
      hist_q <= 6'h00;
    end else begin
      pins_q <= {port2_in, port1_in, port0_in};
      hist_q <= {hist_q[4:0],
                 {port2_in, port1_in, port0_in} != pins_q};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above byte 0 not zero");
  chk_pad_by_write: assert property (
    $changed(pad_drive_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pad drive moved without a write");
  chk_req_drop: assert property (
    $fell(port0_irq) || $fell(port1_irq) || $fell(port2_irq)
    |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("port request fell without a write");
  chk_irq_drop: assert property (
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("irq fell without a write");
  chk_req_cause: assert property (
    $rose(port0_irq) || $rose(port1_irq) || $rose(port2_irq)
    |-> s_axi_bvalid || $past(s_axi_bvalid) || |hist_q)
    else $error("port request rose with no pin edge or write");
  chk_irq_cause: assert property (
    $rose(irq) |-> $rose(port0_irq) || $rose(port1_irq) ||
    $rose(port2_irq) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("irq rose without a request edge");
  chk_ar_to_r: assert property (
    s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late after address taken");
  chk_b_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response outlived its handshake");
endmodule
bind ppi_port_irq ppi_props u_ppi_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .port0_in(port0_in), .port1_in(port1_in), .port2_in(port2_in),
  .pad_drive_select(pad_drive_select), .port0_irq(port0_irq),
  .port1_irq(port1_irq), .port2_irq(port2_irq), .irq(irq),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata));

// File: verif/ppi_pins.sv
// Pin driver model standing in for the circuits on the port pins
`timescale 1ns/10ps
module ppi_pins (
  input  wire        ref_clk,
  input  wire        slow,
  input  wire [20:0] pin_set,
  output reg  [7:0]  port0_in,
  output reg  [7:0]  port1_in,
  output reg  [4:0]  port2_in
);
  // Slow mode holds each new level three edges, a sluggish source
  reg [1:0] lag_q = 2'h0;
  initial {port2_in, port1_in, port0_in} = 21'h0;
  always @(posedge ref_clk) begin
    if ({port2_in, port1_in, port0_in} == pin_set)
      lag_q <= 2'h0;
    else if (!slow || lag_q == 2'h3)
      {port2_in, port1_in, port0_in} <= pin_set;
    else
      lag_q <= lag_q + 2'h1;
  end
endmodule

// File: verif/ppi_port_irq_bench.sv
// Self-checking bench for the port interrupt block
`timescale 1ns/10ps
module ppi_port_irq_bench;
  logic        ref_clk = 0, reset_n = 0, slow = 0;
  logic [20:0] ps = 0, old = 0;
  logic [7:0]  p0, p1;
  logic [4:0]  p2;
  logic        pad, q0, q1, q2, irq, awready, wready, bvalid, arready, rvalid;
  logic [9:0]  awaddr = 0, araddr = 0;
  logic [3:0]  strb = 4'hf;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0]  bresp, rresp;
  int          fails = 0, checks = 0, cyc = 0;
  // Reference model state
  logic [7:0]  f0 = 0, f1 = 0, m1 = 0;
  logic [4:0]  f2 = 0;
  logic [6:0]  ctl = 0;
  logic [2:0]  st = 0, msk = 0, pr = 0;
  logic [9:0]  amap [8] = '{10'h224, 10'h228, 10'h22c, 10'h230, 10'h234,
                            10'h240, 10'h244, 10'h238};
  always #5 ref_clk = ~ref_clk;
  ppi_pins u_ppi_pins (.ref_clk(ref_clk), .slow(slow), .pin_set(ps),
    .port0_in(p0), .port1_in(p1), .port2_in(p2));
  ppi_port_irq u_ppi_port_irq (.ref_clk(ref_clk), .reset_n(reset_n),
    .port0_in(p0), .port1_in(p1), .port2_in(p2), .pad_drive_select(pad),
    .port0_irq(q0), .port1_irq(q1), .port2_irq(q2), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Requests and sticky status, status set on a rising request
  task upd();
    logic [2:0] nr;
    nr = {|(f2 & {5{ctl[5]}}), |(f1 & m1),
          |(f0 & {{4{ctl[4]}}, {4{ctl[3]}}})};
    st |= nr & ~pr;
    pr = nr;
  endtask
  function logic [31:0] ev(logic [9:0] a);
    case (a)
      10'h224: return {24'h0, f0};
      10'h228: return {24'h0, f1};
      10'h22c: return {27'h0, f2};
      10'h230: return {25'h0, ctl};
      10'h234: return {24'h0, m1};
      10'h240: return {29'h0, st};
      10'h244: return {29'h0, msk};
      default: return 32'h0;
    endcase
  endfunction
  task wr(logic [9:0] a, logic [31:0] d);
    logic aw, w, b;
    {aw, w, b} = 3'b110;
    @(posedge ref_clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!b) begin
      @(posedge ref_clk);
      if (aw && awready) aw = 0;
      if (w && wready) w = 0;
      {awvalid, wvalid} <= {aw, w};
      if (bvalid) b = 1;
    end
    bready <= 0;
    cmp("bresp", a == 10'h238 ? 32'h2 : 32'h0, bresp);
    // Lane 0 carries every register bit; without it nothing lands
    case (strb[0] ? a : 10'h000)
      10'h224: f0 &= d[7:0];
      10'h228: f1 &= d[7:0];
      10'h22c: f2 &= d[4:0];
      10'h230: ctl = d[6:0];
      10'h234: m1 = d[7:0];
      10'h240: st &= ~d[2:0];
      10'h244: msk = d[2:0];
      default: ;
    endcase
    upd();
  endtask
  task rd(logic [9:0] a);
    logic b;
    b = 0;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!b) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 0;
      if (rvalid) b = 1;
    end
    rready <= 0;
    cmp("rdata", ev(a), rdata);
    cmp("rresp", a == 10'h238 ? 32'h2 : 32'h0, rresp);
  endtask
  // New pin levels; edge sets flags after sync settles
  task pin(logic [20:0] v);
    logic [20:0] sel, e;
    sel = {{5{ctl[2]}}, {8{ctl[1]}}, {8{ctl[0]}}};
    ps <= v;
    while ({p2, p1, p0} !== v) @(posedge ref_clk);
    repeat (5) @(posedge ref_clk);
    e = (v & ~old & ~sel) | (~v & old & sel);
    {f2, f1, f0} = {f2, f1, f0} | e;
    old = v;
    upd();
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    int r;
    logic [4:0] ex;
    r = $urandom(32'hd963_2827);
    repeat (5) @(posedge ref_clk);
    reset_n <= 1;
    foreach (amap[i]) rd(amap[i]);
    repeat (400) begin
      r = $urandom;
      slow <= r[0];
      strb <= r[13:10] | {3'h0, r[14]};
      if (r[1]) pin(r[31:11]);
      else wr(amap[r[6:4]], $urandom);
      @(posedge ref_clk);
      ex = {ctl[6], pr, |(st & msk)};
      cmp("outs", ex, {pad, q2, q1, q0, irq});
      rd(amap[r[9:7]]);
    end
    end_sim();
  end
endmodule
